/* host_bus_model.sv */
module host_bus_model (
    input  wire logic       clk_i, mode_i, done_i,
    input  wire logic [7:0] bus_i,
    output logic      [2:0] ctl_o, addr_o,
    output logic      [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Deselected, strobes high; ctl is chip select, rw or wr, ds or rd
    initial {ctl_o, addr_o, data_o} = 14'h3800;
    // One access; hold keeps the strobe that many edges past done
    task automatic access(input logic wr, input logic [2:0] a,
        input logic [7:0] d, input int hold, output int n,
        output logic [7:0] q);
        n = 0;
        ctl_o <= {1'b0, !wr, !mode_i && wr};
        {addr_o, data_o} <= {a, d};
        @(posedge clk_i);
        while (!done_i && n < 30) begin
            @(posedge clk_i);
            n++;
        end
        // Done is read one edge after the edge that launched it
        n--;
        q = bus_i;
        repeat (hold) @(posedge clk_i);
        // Release; address and data turn over so stale values show
        ctl_o <= 3'h7;
        {addr_o, data_o} <= {~a, ~d};
        for (int i = 0; i < 8 && done_i; i++) @(posedge clk_i);
        // Completion that never drops spoils the latency on purpose
        if (done_i) n = 99;
    endtask : access
endmodule : host_bus_model

/* host_port_access_handshake.sv */
`include "host_port_map.svh"

// Summary of operation
// R1: Strap low selects separate write/read strobes with active-high ready.
// R2: Strap high selects read-not-write, data strobe, active-low acknowledge.
// R3: Separate-strobe write: ready rises 4 to 9 clocks after strobe, typ 5.
// R4: Separate-strobe read: ready rises 8 to 13 clocks, typ 10, data valid.
// R5: Strobe-ack write: acknowledge falls 4 to 9 clocks after start, typ 5.
// R6: Strobe-ack read: acknowledge falls 8 to 13 clocks after strobe.
// R7: Control inputs and chip select are captured on rising master clock.
// R8: Latency depends on the port address, within the access bounds.
// R9: Read maximum of 13 clocks applies to addresses 7,6,5,3,2,1; the code reaches 13 only at addresses 3 and 7.
// R10: Host holds strobe, address and data until completion is signalled.
module host_port_access_handshake
    import host_port_pkg::*;
#(
    parameter int WR_LAT_BASE = `HP_WR_LAT_TYP,
    parameter int RD_LAT_BASE = `HP_RD_LAT_TYP
) (
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    // Mode strap
    input  wire logic       mode_i,
    // Host control pins
    input  wire logic       cs_n_i,
    input  wire logic       rw_wr_n_i,
    input  wire logic       ds_rd_n_i,
    input  wire logic [2:0] addr_i,
    // Host data bus, three signals per pin
    input  wire logic [7:0] data_i,
    output logic      [7:0] data_o,
    output logic            data_oe_o,
    // Completion: ready (separate) and transfer_ack_n (strobe-ack)
    output logic            rdy_o,
    output logic            transfer_ack_n_o,
    // Internal register file side
    output reg_req_t        req_o,
    output logic            req_valid_o,
    input  wire logic [7:0] reg_rdata_i
);

    localparam int CNT_W = 4;

    // Base plus the address extra must stay inside the access bounds
    if (WR_LAT_BASE < `HP_WR_LAT_MIN
        || WR_LAT_BASE + 3 > `HP_WR_LAT_MAX) begin : g_wr_lat_chk
        $error("WR_LAT_BASE out of range");
    end
    if (RD_LAT_BASE < `HP_RD_LAT_MIN
        || RD_LAT_BASE + 3 > `HP_RD_LAT_MAX) begin : g_rd_lat_chk
        $error("RD_LAT_BASE out of range");
    end
    // The longest latency must fit the down-counter
    if (RD_LAT_BASE + 3 >= 2 ** CNT_W) begin : g_cnt_chk
        $error("CNT_W too narrow for RD_LAT_BASE");
    end

    typedef enum logic [1:0] {
        st_idle,
        st_wait,
        st_done
    } hp_state_t;

    // Two-flop synchronisers for the control pins from the host
    // The strap goes through them too: a jumper may move while running
    host_ctrl_t ctrl_meta_reg, ctrl_sync_reg;
    logic       mode_meta_reg, mode_sync_reg;
    logic       mode_sync;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_meta_reg <= '{cs_n: 1'b1, wr_strobe: 1'b1, rd_strobe: 1'b1};
            ctrl_sync_reg <= '{cs_n: 1'b1, wr_strobe: 1'b1, rd_strobe: 1'b1};
            mode_meta_reg <= 1'h0;
            mode_sync_reg <= 1'h0;
        end else begin
            ctrl_meta_reg <= '{cs_n: cs_n_i, wr_strobe: rw_wr_n_i,
                               rd_strobe: ds_rd_n_i}; // see R7
            ctrl_sync_reg <= ctrl_meta_reg;
            mode_meta_reg <= mode_i;
            mode_sync_reg <= mode_meta_reg;
        end
    end

    assign mode_sync = mode_sync_reg;

    // Decode a request per bus style
    // In strobe-and-ack style the read-not-write level qualifies the strobe
    bus_style_t style;
    logic       start_wr, start_rd, strobe_live;

    always_comb begin
        style = bus_style_t'(mode_sync); // see R1 see R2
        if (style == separate_strobe_style) begin
            start_wr    = !ctrl_sync_reg.cs_n && !ctrl_sync_reg.wr_strobe;
            start_rd    = !ctrl_sync_reg.cs_n && !ctrl_sync_reg.rd_strobe;
            strobe_live = !ctrl_sync_reg.wr_strobe
                          || !ctrl_sync_reg.rd_strobe;
        end else begin
            start_wr    = !ctrl_sync_reg.cs_n && !ctrl_sync_reg.rd_strobe
                          && !ctrl_sync_reg.wr_strobe;
            start_rd    = !ctrl_sync_reg.cs_n && !ctrl_sync_reg.rd_strobe
                          && ctrl_sync_reg.wr_strobe;
            strobe_live = !ctrl_sync_reg.rd_strobe;
        end
    end

    // Address-dependent extra latency, within bounds
    // Two synchroniser edges and the idle-to-wait edge pass before the
    // counter runs, so the load is trimmed by three below
    function automatic logic [CNT_W-1:0] lat_for(input logic wr,
                                                 input logic [2:0] a);
        logic [CNT_W-1:0] extra;
        extra = {2'h0, a[1:0]};  // 0..3 extra clocks by address
        if (wr)
            lat_for = CNT_W'(WR_LAT_BASE) + extra; // see R3 see R5 see R8
        else
            lat_for = CNT_W'(RD_LAT_BASE) + extra; // see R4 see R6 see R9
    endfunction : lat_for

    // Access sequencer
    // One access at a time; nothing is queued
    hp_state_t        state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic             wr_reg, wr_next;
    logic [2:0]       addr_reg, addr_next;
    logic [7:0]       wdata_reg, wdata_next;
    logic [7:0]       rdata_reg, rdata_next;
    logic             done_reg, done_next;
    logic             pulse_reg, pulse_next;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        wr_next    = wr_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        done_next  = done_reg;
        pulse_next = 1'b0;
        unique case (state_reg)
            st_idle: begin
                done_next = 1'b0;
                if (start_wr || start_rd) begin
                    // Address and data come straight off the pins: they
                    // have stood since the strobe fell two edges ago
                    // Sync stage costs 2 clocks; host holds pins (see R10)
                    wr_next    = start_wr;
                    addr_next  = addr_i;
                    wdata_next = data_i;
                    cnt_next   = lat_for(start_wr, addr_i) - CNT_W'(3);
                    state_next = st_wait;
                end
            end
            st_wait: begin
                // Read data is latched here so that it stands with ready
                if (cnt_reg == '0) begin
                    pulse_next = wr_reg;
                    if (!wr_reg)
                        rdata_next = reg_rdata_i; // Data valid at ready
                    done_next  = 1'b1;
                    state_next = st_done;
                end else begin
                    cnt_next = cnt_reg - CNT_W'(1);
                end
            end
            st_done: begin
                // Completion stands until the strobe is seen released;
                // a new strobe is refused until then
                if (!strobe_live) begin // see R10
                    done_next  = 1'b0;
                    state_next = st_idle;
                end
            end
            default: state_next = st_idle;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= st_idle;
            cnt_reg   <= '0;
            wr_reg    <= 1'b0;
            addr_reg  <= 3'h0;
            wdata_reg <= `HP_DATA_RST;
            rdata_reg <= `HP_DATA_RST;
            done_reg  <= 1'b0;
            pulse_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            wr_reg    <= wr_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            done_reg  <= done_next;
            pulse_reg <= pulse_next;
        end
    end

    // Completion outputs per style
    // The pin of the unused style is parked at its inactive level
    always_comb begin
        rdy_o            = `HP_RDY_RST;
        transfer_ack_n_o = `HP_ACK_N_RST;
        if (style == separate_strobe_style)
            rdy_o = done_reg;             // see R3 see R4
        else
            transfer_ack_n_o = !done_reg; // see R5 see R6
    end

    // Read data driven while a read completes
    // The bus is driven only while select is still seen low, so a host
    // that drops select early gets the bus back two clocks later
    assign data_o      = rdata_reg;
    assign data_oe_o   = done_reg && !wr_reg && !ctrl_sync_reg.cs_n;
    assign req_o       = '{wr: wr_reg, addr: addr_reg, wdata: wdata_reg};
    assign req_valid_o = pulse_reg;

endmodule : host_port_access_handshake

/* host_port_access_handshake_tb.sv */
module host_port_access_handshake_tb;
    import host_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic       mclk_i, rst_n_i, mode_i, cs_n_i, rw_wr_n_i, ds_rd_n_i;
    logic       data_oe_o, rdy_o, transfer_ack_n_o, req_valid_o, done;
    logic [2:0] addr_i, ctl;
    logic [7:0] data_i, data_o, reg_rdata_i, hd;
    reg_req_t   req_o;
    int         n_errors = 0, n_compared = 0, n_pulse = 0;
    logic [10:0] req_seen;
    // Read data owns the bus while driven; host controls fan out
    assign data_i = data_oe_o ? data_o : hd;
    assign {cs_n_i, rw_wr_n_i, ds_rd_n_i} = ctl;
    assign done = mode_i ? !transfer_ack_n_o : rdy_o;
    host_port_access_handshake uut (.*);
    host_bus_model host (.clk_i(mclk_i), .mode_i(mode_i), .done_i(done),
        .bus_i(data_i), .ctl_o(ctl), .addr_o(addr_i), .data_o(hd));
    // Logs each committed write as the register file sees it
    always @(posedge mclk_i) begin
        if (req_valid_o) begin
            req_seen <= {req_o.addr, req_o.wdata};
            n_pulse  <= n_pulse + 1;
        end
    end
    // Master clock
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    task automatic check_rng(input int v, input int lo, input int hi);
        n_compared++;
        if (v < lo || v > hi) n_errors++;
        if (v < lo || v > hi) $display("MISMATCH %0t lat %0d", $time, v);
    endtask : check_rng
    task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) n_errors++;
        if (g !== e) $display("MISMATCH %0t data %h", $time, g);
    endtask : check_byte
    // Both styles, each address, write then read, prompt and slow host
    task automatic t_styles;
        int wl, rl, r0, np;
        logic [7:0] q;
        for (int m = 0; m < 2; m++) begin
            mode_i <= m[0];
            repeat (4) @(posedge mclk_i);
            for (int a = 0; a < 8; a++) begin
                reg_rdata_i <= 8'hA0 | 8'(a);
                np = n_pulse;
                host.access(1'b1, 3'(a), 8'h50 | 8'(a), a % 2, wl, q);
                check_rng(wl, 4, 9);
                check_rng(n_pulse - np, 1, 1);
                check_byte(req_seen[7:0], 8'h50 | 8'(a));
                check_byte({5'h00, req_seen[10:8]}, 8'(a));
                host.access(1'b0, 3'(a), 8'h00, a % 2, rl, q);
                check_rng(rl, 8, 13);
                check_byte(q, 8'hA0 | 8'(a));
                check_rng(n_pulse - np, 1, 1);
                if (a == 0) r0 = rl;
            end
            check_rng(rl - r0, 1, 5);
        end
        $display("test styles done");
    endtask : t_styles
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test
    initial begin
        {rst_n_i, mode_i, reg_rdata_i} = 10'h000;
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t_styles();
        finish_test();
    end
endmodule : host_port_access_handshake_tb

/* host_port_checker_assertions.sv */
module host_port_checker
    import host_port_pkg::*;
(
    input wire logic       mclk_i, rst_n_i, mode_i, cs_n_i, rw_wr_n_i,
    input wire logic       ds_rd_n_i, data_oe_o, rdy_o, transfer_ack_n_o,
    input wire logic [7:0] data_o, reg_rdata_i
);
    logic       act, rd, done, wr_ok, rd_ok;
    logic [3:0] cnt_reg, cnt_next, lat;
    // Strobe, direction, completion and latency windows
    assign act = !cs_n_i && !(mode_i ? ds_rd_n_i : rw_wr_n_i && ds_rd_n_i);
    assign rd = mode_i ? rw_wr_n_i : !ds_rd_n_i;
    assign done = mode_i ? !transfer_ack_n_o : rdy_o;
    // The count includes the edge that launches completion; drop it
    assign lat = cnt_reg - 4'h1;
    assign wr_ok = lat inside {[4'h4:4'h9]};
    assign rd_ok = lat inside {[4'h8:4'hD]};
    // Edges since the strobe went active, held at 15
    always_comb cnt_next = act ? cnt_reg + {3'h0, cnt_reg != 4'hF} : 4'h0;
    always_ff @(posedge mclk_i or negedge rst_n_i)
        cnt_reg <= !rst_n_i ? 4'h0 : cnt_next;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sep_wr_a: assert property ($rose(rdy_o) && !rd |-> wr_ok)
        else $error("write ready time");
    sep_rd_a: assert property ($rose(rdy_o) && rd |-> rd_ok)
        else $error("read ready time");
    ack_wr_a: assert property ($fell(transfer_ack_n_o) && !rd |-> wr_ok)
        else $error("write ack time");
    ack_rd_a: assert property ($fell(transfer_ack_n_o) && rd |-> rd_ok)
        else $error("read ack time");
    sep_pins_a: assert property (!mode_i [*3] |-> transfer_ack_n_o)
        else $error("ack in strobe style");
    ack_pins_a: assert property (mode_i [*3] |-> !rdy_o)
        else $error("ready in ack style");
    idle_quiet_a: assert property (!act [*6] |-> !done)
        else $error("done without strobe");
    rd_data_a: assert property ($rose(done) && rd |->
        data_oe_o && data_o == reg_rdata_i) else $error("read data");
endmodule : host_port_checker
bind host_port_access_handshake host_port_checker chk (.*);

/* host_port_map.svh */
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH

// Master clock period in picoseconds (10 ns)
`define HP_CLK_PERIOD_PS   10000
// Write access: min 4, typical 5, max 9 master clock periods
`define HP_WR_LAT_MIN      4
`define HP_WR_LAT_TYP      5
`define HP_WR_LAT_MAX      9
// Read access: min 8, typical 10, max 13 master clock periods
`define HP_RD_LAT_MIN      8
`define HP_RD_LAT_TYP      10
`define HP_RD_LAT_MAX      13
// Reset values
`define HP_RDY_RST         1'b0
`define HP_ACK_N_RST       1'b1
`define HP_DATA_RST        8'h00

`endif

/* host_port_pkg.sv */
package host_port_pkg;

    // Bus style selected by the mode strap
    typedef enum logic {
        separate_strobe_style = 1'b0,
        strobe_ack_style      = 1'b1
    } bus_style_t;

    // Host-side control pins after synchronisation
    typedef struct packed {
        logic cs_n;
        logic wr_strobe;  // Write strobe low, or read-not-write level
        logic rd_strobe;  // Read strobe low, or data strobe low
    } host_ctrl_t;

    // Request to the internal register file
    typedef struct packed {
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage : host_port_pkg
